//--- include/tca_pkg.sv
// Constants and types shared by the transfer count and activation control block
package tca_pkg;
	// Register byte offsets
	localparam logic [5:0] TCA_OFS_ACT_EN_A = 6'h00;
	localparam logic [5:0] TCA_OFS_CTRL = 6'h20;
	localparam logic [5:0] TCA_OFS_IRQ_STATUS = 6'h24;
	localparam logic [5:0] TCA_OFS_IRQ_CLEAR = 6'h28;
	localparam logic [5:0] TCA_OFS_IRQ_ENABLE = 6'h2c;
	// Register word indices derived from the offsets
	localparam logic [3:0] TCA_IDX_CTRL = TCA_OFS_CTRL[5:2];
	localparam logic [3:0] TCA_IDX_IRQ_STATUS = TCA_OFS_IRQ_STATUS[5:2];
	localparam logic [3:0] TCA_IDX_IRQ_CLEAR = TCA_OFS_IRQ_CLEAR[5:2];
	localparam logic [3:0] TCA_IDX_IRQ_ENABLE = TCA_OFS_IRQ_ENABLE[5:2];
	// Geometry of the activation enable set
	localparam int TCA_NUM_EN_REGS = 8;
	localparam int TCA_EN_WIDTH = 16;
	// Control register field positions
	localparam int TCA_CTRL_ERR_BIT = 0;
	localparam int TCA_CTRL_RELOAD_CHAIN_EN_BIT = 3;
	localparam int TCA_CTRL_RRS_BIT = 4;
	// Interrupt status field positions
	localparam int TCA_IRQ_XFER_BIT = 0;
	localparam int TCA_IRQ_ERR_BIT = 1;
	localparam int TCA_IRQ_WIDTH = 2;
	// Reset values
	localparam logic [15:0] TCA_ACT_EN_RST = 16'h0000;
	localparam logic [7:0] TCA_CTRL_RST = 8'h00;
	localparam logic [15:0] TCA_BLOCK_COUNT_RST = 16'h0000;
	localparam logic [7:0] TCA_LAST_VEC_RST = 8'h00;
	// Block count value that ends the count on its next transfer
	localparam logic [15:0] TCA_BLOCK_COUNT_LAST = 16'h0001;
	// AXI responses
	localparam logic [1:0] TCA_RESP_OKAY = 2'b00;
	localparam logic [1:0] TCA_RESP_SLVERR = 2'b10;
	// Transfer modes of the active transfer information
	typedef enum logic [1:0] {
		TCA_MODE_NORMAL,
		TCA_MODE_REPEAT,
		TCA_MODE_BLOCK
	} tca_mode_t;
endpackage

//--- verilog/tca_ctl.sv
// Transfer count, activation enable and control register logic of the transfer controller
`timescale 1ns/100ps

// Functional notes
// - Block mode keeps a 16-bit block count, decremented once per transfer.
// - At block count zero, clear the source enable bit, then request CPU interrupt.
// - Count value is the transfer number; zero stands for 65,536 transfers.
// - Block count unused in normal and repeat modes; CPU cannot reach it.
// - Eight 16-bit enable registers reset to zero; a one routes source to transfers.
// - Writing 0 after reading 1 clears an enable bit.
// - Hardware clears enable bit on per-transfer interrupt select or count completion; code skips the clear when a chain transfer follows.
// - Control bits 7 to 5 and 2 to 1 always read as zero.
// - Matching vector number with read skip enabled starts without fetching information.
// - After a chained activation the vector and information are always fetched.
// - Stop flag resets to zero; software can only clear it, writing 1 ignored.
// - Address error or NMI sets stop flag and halts; cleared by 0 after 1.
// - With reload chain enable set, repeat-mode reload allows a chain transfer.
// - Per-transfer select requests interrupt after every transfer, else at count end; code requests none when a chain transfer follows.
module tca_ctl #(
	parameter int VEC_WIDTH = 8,
	parameter int SRC_WIDTH = 7
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Activation request from the interrupt side
	input wire logic act_valid,
	input wire logic [VEC_WIDTH-1:0] act_vector,
	input wire logic act_chain,
	output logic act_ack,
	output logic act_skip_fetch,
	// Transfer information load
	input wire logic info_load,
	input wire tca_pkg::tca_mode_t info_mode,
	input wire logic [15:0] info_block_count,
	input wire logic info_per_xfer_irq,
	// Transfer completion from the engine
	input wire logic xfer_done,
	input wire logic [SRC_WIDTH-1:0] xfer_src,
	input wire logic xfer_chain_next,
	input wire logic xfer_count_done,
	input wire logic repeat_reload,
	// Fault inputs
	input wire logic addr_error,
	input wire logic nmi_event,
	// Outputs to engine, interrupt controller and CPU
	output logic [127:0] source_activation_bits,
	output logic [15:0] block_count_reg,
	output logic reload_chain_ok,
	output logic xfer_halt,
	output logic cpu_irq_req,
	output logic [SRC_WIDTH-1:0] cpu_irq_src,
	output logic irq
);
	import tca_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [5:0] aw_addr_ff;
	logic aw_got_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic w_got_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic [TCA_EN_WIDTH-1:0] act_en_ff [TCA_NUM_EN_REGS];
	logic [TCA_EN_WIDTH-1:0] en_armed_ff [TCA_NUM_EN_REGS];
	logic rrs_ff;
	logic reload_chain_en_ff;
	logic err_ff;
	logic err_armed_ff;
	logic [TCA_IRQ_WIDTH-1:0] irq_status_ff;
	logic [TCA_IRQ_WIDTH-1:0] irq_enable_ff;
	logic irq_ff;
	logic [15:0] block_count_ff;
	tca_mode_t mode_ff;
	logic per_xfer_irq_ff;
	logic [VEC_WIDTH-1:0] last_vec_ff;
	logic last_chain_ff;
	logic last_valid_ff;
	logic act_ack_ff;
	logic skip_ff;
	logic end_pend_ff;
	logic [SRC_WIDTH-1:0] end_src_ff;
	logic cpu_req_ff;
	logic [SRC_WIDTH-1:0] cpu_src_ff;
	logic reload_ok_ff;
	logic awready_ff;
	logic wready_ff;
	logic arready_ff;
	logic do_write;
	logic do_read;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	logic wr_lo;
	logic wr_hi;
	logic count_end;
	logic end_evt;
	logic err_evt;
	logic [2:0] end_reg;
	logic [3:0] end_bit;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake decode
	assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
	assign do_read = s_axi_arvalid && !rvalid_ff;
	assign wr_idx = aw_addr_ff[5:2];
	assign rd_idx = s_axi_araddr[5:2];
	assign wr_lo = w_strb_ff[0];
	assign wr_hi = w_strb_ff[1];

	// Write address and data are taken independently, released at response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			awready_ff <= 1'b1;
			aw_addr_ff <= 6'h00;
		end else if (s_axi_awvalid && !aw_got_ff) begin
			aw_got_ff <= 1'b1;
			awready_ff <= 1'b0;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got_ff <= 1'b0;
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_ff <= 1'b0;
			wready_ff <= 1'b1;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
		end else if (s_axi_wvalid && !w_got_ff) begin
			w_got_ff <= 1'b1;
			wready_ff <= 1'b0;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_got_ff <= 1'b0;
			wready_ff <= 1'b1;
		end
	end

	// Write response, error for unmapped words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= TCA_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_idx > TCA_IDX_IRQ_ENABLE) ? TCA_RESP_SLVERR : TCA_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read data path; CPU has no path to the block count
	// no block count window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
			rresp_ff <= TCA_RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (do_read) begin
			rvalid_ff <= 1'b1;
			arready_ff <= 1'b0;
			rresp_ff <= TCA_RESP_OKAY;
			rdata_ff <= 32'h00000000;
			if (rd_idx < 4'(TCA_NUM_EN_REGS)) begin
				rdata_ff[15:0] <= act_en_ff[rd_idx[2:0]];
			end else if (rd_idx == TCA_IDX_CTRL) begin
				rdata_ff[TCA_CTRL_RRS_BIT] <= rrs_ff;
				rdata_ff[TCA_CTRL_RELOAD_CHAIN_EN_BIT] <= reload_chain_en_ff;
				rdata_ff[TCA_CTRL_ERR_BIT] <= err_ff;
			end else if (rd_idx == TCA_IDX_IRQ_STATUS) begin
				rdata_ff[TCA_IRQ_WIDTH-1:0] <= irq_status_ff;
			end else if (rd_idx == TCA_IDX_IRQ_ENABLE) begin
				rdata_ff[TCA_IRQ_WIDTH-1:0] <= irq_enable_ff;
			end else if (rd_idx != TCA_IDX_IRQ_CLEAR) begin
				rresp_ff <= TCA_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer end handling
	// zero wraps to 16'hffff so it yields 65,536 transfers
	assign count_end = (mode_ff == TCA_MODE_BLOCK) ? (block_count_ff == TCA_BLOCK_COUNT_LAST)
		: xfer_count_done;
	// clear on per-transfer select or count completion, never mid-chain
	assign end_evt = xfer_done && !xfer_chain_next && (per_xfer_irq_ff || count_end);
	assign end_reg = xfer_src[6:4];
	assign end_bit = 4'hf - xfer_src[3:0];
	assign err_evt = addr_error || nmi_event;

	// Transfer information held for the active transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= TCA_MODE_NORMAL;
			per_xfer_irq_ff <= 1'b0;
		end else if (info_load) begin
			mode_ff <= info_mode;
			per_xfer_irq_ff <= info_per_xfer_irq;
		end
	end

	// Block count: loaded in block mode, one step per transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_count_ff <= TCA_BLOCK_COUNT_RST;
		end else if (info_load && info_mode == TCA_MODE_BLOCK) begin
			block_count_ff <= info_block_count;
		end else if (xfer_done && mode_ff == TCA_MODE_BLOCK) begin
			block_count_ff <= block_count_ff - 16'h0001;
		end
	end

	// Activation enables: hardware clear, then software access
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int r = 0; r < TCA_NUM_EN_REGS; r++) begin
				act_en_ff[r] <= TCA_ACT_EN_RST;
			end
		end else begin
			if (end_evt) begin
				act_en_ff[end_reg][end_bit] <= 1'b0;
			end
			if (do_write && wr_idx < 4'(TCA_NUM_EN_REGS)) begin
				for (int b = 0; b < TCA_EN_WIDTH; b++) begin
					// zero clears only after a read of one
					if ((b < 8) ? wr_lo : wr_hi) begin
						if (w_data_ff[b]) begin
							act_en_ff[wr_idx[2:0]][b] <= 1'b1;
						end else if (en_armed_ff[wr_idx[2:0]][b]) begin
							act_en_ff[wr_idx[2:0]][b] <= 1'b0;
						end
					end
				end
			end
		end
	end

	// Read-as-one marks, disarmed by any write to that register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int r = 0; r < TCA_NUM_EN_REGS; r++) begin
				en_armed_ff[r] <= TCA_ACT_EN_RST;
			end
		end else begin
			if (do_write && wr_idx < 4'(TCA_NUM_EN_REGS)) begin
				en_armed_ff[wr_idx[2:0]] <= TCA_ACT_EN_RST;
			end
			if (do_read && rd_idx < 4'(TCA_NUM_EN_REGS)) begin
				en_armed_ff[rd_idx[2:0]] <= en_armed_ff[rd_idx[2:0]] | act_en_ff[rd_idx[2:0]];
			end
		end
	end

	// Control register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rrs_ff <= TCA_CTRL_RST[TCA_CTRL_RRS_BIT];
			reload_chain_en_ff <= TCA_CTRL_RST[TCA_CTRL_RELOAD_CHAIN_EN_BIT];
		end else if (do_write && wr_idx == TCA_IDX_CTRL && wr_lo) begin
			rrs_ff <= w_data_ff[TCA_CTRL_RRS_BIT];
			reload_chain_en_ff <= w_data_ff[TCA_CTRL_RELOAD_CHAIN_EN_BIT];
		end
	end

	// Stop flag: set by faults, set wins over a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_ff <= TCA_CTRL_RST[TCA_CTRL_ERR_BIT];
			err_armed_ff <= 1'b0;
		end else begin
			if (do_read && rd_idx == TCA_IDX_CTRL) begin
				err_armed_ff <= err_ff;
			end else if (do_write && wr_idx == TCA_IDX_CTRL) begin
				err_armed_ff <= 1'b0;
			end
			if (err_evt) begin
				err_ff <= 1'b1;
			// only a zero after a read of one clears
			end else if (do_write && wr_idx == TCA_IDX_CTRL && wr_lo
				&& !w_data_ff[TCA_CTRL_ERR_BIT] && err_armed_ff) begin
				err_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Activation and read skip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_vec_ff <= TCA_LAST_VEC_RST;
			last_chain_ff <= 1'b0;
			last_valid_ff <= 1'b0;
			act_ack_ff <= 1'b0;
			skip_ff <= 1'b0;
		end else begin
			act_ack_ff <= act_valid;
			if (act_valid) begin
				// skip on matching vector; never after a chain
				skip_ff <= rrs_ff && last_valid_ff && !last_chain_ff && act_vector == last_vec_ff;
				last_vec_ff <= act_vector;
				last_chain_ff <= act_chain;
				last_valid_ff <= 1'b1;
			end
		end
	end

	// CPU request one cycle after the enable clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			end_pend_ff <= 1'b0;
			end_src_ff <= '0;
			cpu_req_ff <= 1'b0;
			cpu_src_ff <= '0;
		end else begin
			// request on each transfer without chain next under per-transfer select, or at count end without chain next
			end_pend_ff <= end_evt;
			end_src_ff <= xfer_src;
			cpu_req_ff <= end_pend_ff;
			if (end_pend_ff) begin
				cpu_src_ff <= end_src_ff;
			end
		end
	end

	// Chain permission at repeat reload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_ok_ff <= 1'b0;
		end else begin
			reload_ok_ff <= repeat_reload && reload_chain_en_ff && mode_ff == TCA_MODE_REPEAT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, enable and output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_ff <= '0;
			irq_enable_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			for (int i = 0; i < TCA_IRQ_WIDTH; i++) begin
				if ((i == TCA_IRQ_XFER_BIT && cpu_req_ff) || (i == TCA_IRQ_ERR_BIT && err_evt)) begin
					irq_status_ff[i] <= 1'b1;
				end else if (do_write && wr_idx == TCA_IDX_IRQ_CLEAR && wr_lo && w_data_ff[i]) begin
					irq_status_ff[i] <= 1'b0;
				end
			end
			if (do_write && wr_idx == TCA_IDX_IRQ_ENABLE && wr_lo) begin
				irq_enable_ff <= w_data_ff[TCA_IRQ_WIDTH-1:0];
			end
			irq_ff <= |(irq_status_ff & irq_enable_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign act_ack = act_ack_ff;
	assign act_skip_fetch = skip_ff;
	assign block_count_reg = block_count_ff;
	assign reload_chain_ok = reload_ok_ff;
	assign xfer_halt = err_ff;
	assign cpu_irq_req = cpu_req_ff;
	assign cpu_irq_src = cpu_src_ff;
	assign irq = irq_ff;
	for (genvar g = 0; g < TCA_NUM_EN_REGS; g++) begin : g_en
		assign source_activation_bits[g*16 +: 16] = act_en_ff[g];
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_count_decrement: assert property (
		xfer_done && !info_load && mode_ff == TCA_MODE_BLOCK
		|=> block_count_ff == $past(block_count_ff) - 16'h0001)
		else $error("block count did not step down");
	chk_clear_then_irq: assert property (
		end_evt |=> !act_en_ff[$past(end_reg)][$past(end_bit)] ##1 cpu_irq_req)
		else $error("interrupt not after enable clear");
	chk_zero_wraps: assert property (
		xfer_done && !info_load && mode_ff == TCA_MODE_BLOCK && block_count_ff == 16'h0000
		|=> block_count_ff == 16'hffff && !$past(count_end))
		else $error("zero count did not stand for maximum");
	chk_count_idle: assert property (
		mode_ff != TCA_MODE_BLOCK && !info_load |=> $stable(block_count_ff))
		else $error("block count moved outside block mode");
	chk_ctrl_reserved: assert property (
		s_axi_rvalid && $past(do_read && rd_idx == TCA_IDX_CTRL)
		|-> s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[2:1] == 2'h0)
		else $error("reserved control bits read nonzero");
	chk_skip_rule: assert property (
		act_valid && rrs_ff && last_valid_ff && !last_chain_ff && act_vector == last_vec_ff
		|=> act_ack && act_skip_fetch)
		else $error("read skip not taken on match");
	chk_chain_fetch: assert property (
		act_valid && last_chain_ff |=> !act_skip_fetch)
		else $error("skip after chained activation");
	chk_err_sticky: assert property (
		err_ff && !err_armed_ff |=> err_ff)
		else $error("stop flag cleared without read");
	chk_fault_halts: assert property (
		err_evt |=> xfer_halt ##1 irq_status_ff[TCA_IRQ_ERR_BIT])
		else $error("fault did not halt");
	chk_reload_chain: assert property (
		repeat_reload && mode_ff == TCA_MODE_REPEAT |=> reload_chain_ok == $past(reload_chain_en_ff))
		else $error("reload chain permission wrong");
	chk_irq_each: assert property (
		xfer_done && per_xfer_irq_ff && !xfer_chain_next |-> ##2 cpu_irq_req)
		else $error("per-transfer request missing");

	cov_block_end: cover property (end_evt && mode_ff == TCA_MODE_BLOCK ##2 cpu_irq_req);
	cov_skip: cover property (act_ack && act_skip_fetch);
	cov_err_clear: cover property (err_ff ##1 !err_ff);
endmodule

//--- bench/tca_src_model.sv
// Behavioural model of the interrupt sources and transfer engine feeding the block
`timescale 1ns/100ps
module tca_src_model (
	// Clock
	input wire logic aclk,
	// Activation request
	output logic act_valid,
	output logic [7:0] act_vector,
	output logic act_chain,
	// Transfer information
	output logic info_load,
	output tca_pkg::tca_mode_t info_mode,
	output logic [15:0] info_block_count,
	output logic info_per_xfer_irq,
	// Transfer completion and faults
	output logic xfer_done,
	output logic [6:0] xfer_src,
	output logic xfer_chain_next,
	output logic xfer_count_done,
	output logic repeat_reload,
	output logic addr_error,
	output logic nmi_event
);
	import tca_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Idle levels at time zero
	initial begin
		{act_valid, act_chain, info_load, info_per_xfer_irq, xfer_done} = '0;
		{xfer_chain_next, xfer_count_done, repeat_reload, addr_error, nmi_event} = '0;
		act_vector = 8'h00;
		info_mode = TCA_MODE_NORMAL;
		info_block_count = 16'h0000;
		xfer_src = 7'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle activation; the vector is scrambled once released
	task act(input logic [7:0] v, input logic c);
		@(posedge aclk);
		act_valid <= 1'b1;
		act_vector <= v;
		act_chain <= c;
		@(posedge aclk);
		act_valid <= 1'b0;
		act_vector <= ~v;
	endtask

	// Transfer information load pulse
	task ld(input tca_mode_t m, input logic [15:0] n, input logic p);
		@(posedge aclk);
		info_load <= 1'b1;
		info_mode <= m;
		info_block_count <= n;
		info_per_xfer_irq <= p;
		@(posedge aclk);
		info_load <= 1'b0;
		info_block_count <= ~n;
	endtask

	// One transfer ended, with its chain and count qualifiers
	task done(input logic [6:0] s, input logic ch, input logic cd);
		@(posedge aclk);
		xfer_done <= 1'b1;
		xfer_src <= s;
		xfer_chain_next <= ch;
		xfer_count_done <= cd;
		@(posedge aclk);
		xfer_done <= 1'b0;
		xfer_chain_next <= 1'b0;
		xfer_count_done <= 1'b0;
		xfer_src <= ~s;
	endtask

	// Lower counter reload pulse
	task rl;
		@(posedge aclk);
		repeat_reload <= 1'b1;
		@(posedge aclk);
		repeat_reload <= 1'b0;
	endtask

	// Address error or non-maskable interrupt pulse
	task flt(input logic nmi);
		@(posedge aclk);
		addr_error <= !nmi;
		nmi_event <= nmi;
		@(posedge aclk);
		addr_error <= 1'b0;
		nmi_event <= 1'b0;
	endtask
endmodule

//--- bench/transfer_count_activation_ctl_tb.sv
// Self-checking bench for the transfer count and activation control block
`timescale 1ns/100ps
module transfer_count_activation_ctl_tb;
	import tca_pkg::*;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, last_data;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic act_valid, act_chain, act_ack, act_skip_fetch, info_load, info_per_xfer_irq;
	logic [7:0] act_vector;
	tca_mode_t info_mode;
	logic [15:0] info_block_count, block_count_reg;
	logic xfer_done, xfer_chain_next, xfer_count_done, repeat_reload, addr_error, nmi_event;
	logic [6:0] xfer_src, cpu_irq_src, last_src;
	logic [127:0] source_activation_bits, bits_at_req;
	logic reload_chain_ok, xfer_halt, cpu_irq_req, irq;
	int mismatches, checks_done, req_cnt, chain_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// Design and far-side model
	tca_ctl tca_ctl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .act_valid, .act_vector, .act_chain,
		.act_ack, .act_skip_fetch, .info_load, .info_mode, .info_block_count,
		.info_per_xfer_irq, .xfer_done, .xfer_src, .xfer_chain_next, .xfer_count_done,
		.repeat_reload, .addr_error, .nmi_event, .source_activation_bits, .block_count_reg,
		.reload_chain_ok, .xfer_halt, .cpu_irq_req, .cpu_irq_src, .irq);
	tca_src_model tca_src_model_inst (.aclk, .act_valid, .act_vector, .act_chain, .info_load,
		.info_mode, .info_block_count, .info_per_xfer_irq, .xfer_done, .xfer_src,
		.xfer_chain_next, .xfer_count_done, .repeat_reload, .addr_error, .nmi_event);

	// Clock
	always #5 aclk = ~aclk;

	// Count interrupt requests and chain grants, keep what a request saw
	always @(posedge aclk) begin
		if (cpu_irq_req) begin
			req_cnt++;
			last_src <= cpu_irq_src;
			bits_at_req <= source_activation_bits;
		end
		if (reload_chain_ok)
			chain_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Address and data offered together, each released when taken
	task wr(input logic [5:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		last_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [5:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		last_data = s_axi_rdata;
		last_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task rc(input logic [5:0] a, input logic [31:0] exp);
		rd(a);
		cmp(last_data, exp);
	endtask

	// Activation, then its one-cycle acknowledge with the fetch decision
	task sk(input logic [7:0] v, input logic c, input logic exp);
		tca_src_model_inst.act(v, c);
		cyc(1);
		cmp({act_ack, act_skip_fetch}, {1'b1, exp});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		cyc(6000);
		mismatches++;
		conclude;
	end

	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		{mismatches, checks_done, req_cnt, chain_cnt} = '0;
		cyc(3);
		aresetn <= 1'b1;
		// Reset values and unmapped access
		for (int i = 0; i < 10; i++)
			rc(6'(i * 4), 32'h0000_0000);
		cmp(block_count_reg, 32'h0000_0000);
		rd(6'h30);
		cmp(last_resp, TCA_RESP_SLVERR);
		wr(6'h30, 32'h0000_ffff);
		cmp(last_resp, TCA_RESP_SLVERR);
		// Single-bit set, then clearing only after a read of one
		wr(6'h00, 32'h0000_8000);
		rc(6'h00, 32'h0000_8000);
		wr(6'h00, 32'h0000_8000);
		wr(6'h00, 32'h0000_0000);
		rc(6'h00, 32'h0000_8000);
		wr(6'h00, 32'h0000_0000);
		rc(6'h00, 32'h0000_0000);
		// Control register read-only bits and flag
		wr(TCA_OFS_CTRL, 32'h0000_00ff);
		rc(TCA_OFS_CTRL, 32'h0000_0018);
		tca_src_model_inst.ld(TCA_MODE_REPEAT, 16'h0000, 1'b0);
		tca_src_model_inst.rl();
		cyc(3);
		cmp(chain_cnt, 1);
		wr(TCA_OFS_CTRL, 32'h0000_0010);
		tca_src_model_inst.rl();
		cyc(3);
		cmp(chain_cnt, 1);
		// Fetch skip decisions
		sk(8'h05, 1'b0, 1'b0);
		sk(8'h05, 1'b0, 1'b1);
		sk(8'h06, 1'b0, 1'b0);
		sk(8'h06, 1'b1, 1'b1);
		sk(8'h06, 1'b0, 1'b0);
		wr(TCA_OFS_CTRL, 32'h0000_0000);
		sk(8'h06, 1'b0, 1'b0);
		// Block mode count end on enable register b bit 0
		wr(TCA_OFS_IRQ_ENABLE, 32'h0000_0001);
		wr(6'h04, 32'h0000_0001);
		tca_src_model_inst.ld(TCA_MODE_BLOCK, 16'h0002, 1'b0);
		tca_src_model_inst.done(7'h1f, 1'b0, 1'b0);
		cyc(5);
		cmp(block_count_reg, 32'h0000_0001);
		cmp(source_activation_bits[16], 1'b1);
		cmp(req_cnt, 0);
		tca_src_model_inst.done(7'h1f, 1'b0, 1'b0);
		cyc(5);
		cmp(block_count_reg, 32'h0000_0000);
		cmp(source_activation_bits[16], 1'b0);
		cmp(bits_at_req[16], 1'b0);
		cmp({req_cnt[7:0], 1'b0, last_src}, {8'h01, 8'h1f});
		cmp(irq, 1'b1);
		rc(TCA_OFS_IRQ_STATUS, 32'h0000_0001);
		wr(TCA_OFS_IRQ_CLEAR, 32'h0000_0001);
		cyc(3);
		cmp(irq, 1'b0);
		// Zero count means the largest count
		tca_src_model_inst.ld(TCA_MODE_BLOCK, 16'h0000, 1'b0);
		tca_src_model_inst.done(7'h1f, 1'b1, 1'b0);
		cyc(3);
		cmp(block_count_reg, 32'h0000_ffff);
		// Per-transfer interrupt select, masked interrupt
		wr(TCA_OFS_IRQ_ENABLE, 32'h0000_0000);
		wr(6'h00, 32'h0000_4000);
		tca_src_model_inst.ld(TCA_MODE_NORMAL, 16'h0005, 1'b1);
		tca_src_model_inst.done(7'h01, 1'b1, 1'b0);
		cyc(5);
		cmp({source_activation_bits[14], req_cnt[7:0]}, {1'b1, 8'h01});
		tca_src_model_inst.done(7'h01, 1'b0, 1'b0);
		cyc(5);
		cmp({source_activation_bits[14], req_cnt[7:0]}, {1'b0, 8'h02});
		cmp(block_count_reg, 32'h0000_ffff);
		cmp(irq, 1'b0);
		rc(TCA_OFS_IRQ_STATUS, 32'h0000_0001);
		// Count completion without per-transfer select
		wr(6'h00, 32'h0000_2000);
		tca_src_model_inst.ld(TCA_MODE_NORMAL, 16'h0002, 1'b0);
		tca_src_model_inst.done(7'h02, 1'b0, 1'b0);
		cyc(5);
		cmp({source_activation_bits[13], req_cnt[7:0]}, {1'b1, 8'h02});
		tca_src_model_inst.done(7'h02, 1'b0, 1'b1);
		cyc(5);
		cmp({source_activation_bits[13], req_cnt[7:0]}, {1'b0, 8'h03});
		// Faults set the stop flag, cleared by zero after one
		for (int k = 0; k < 2; k++) begin
			tca_src_model_inst.flt(k[0]);
			cyc(3);
			cmp(xfer_halt, 1'b1);
			rc(TCA_OFS_CTRL, 32'h0000_0001);
			wr(TCA_OFS_CTRL, 32'h0000_0000);
			rc(TCA_OFS_CTRL, 32'h0000_0000);
			cmp(xfer_halt, 1'b0);
		end
		conclude;
	end
endmodule
